// *** fspl_pkg.sv ***
// Constants, types and decode helpers for the fuse start-up and
// partition/lock loader.
// Assumes a 20 MHz reference clock and an AHB-Lite register bus.
// Summary of operation
// - Start-up code 0..7 holds execution for 0,1,2,4,8,16,32,64 ms.
// - Application-code-end byte gives code end in 256-byte blocks.
// - Flash above the application code end is application data.
// - Code-end byte zero: code runs from boot end to flash end.
// - Boot-end byte gives boot section end in 256-byte blocks.
// - Boot-end byte zero makes the entire flash boot section.
// - Open only when lock byte is 0xc5; locked denies debug bus access.
// - Locked debug port reads only its own control/status space.
// - Chip erase on a locked part always erases EEPROM.
package fspl_pkg;
	// Timebase
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned DLY_UNIT_MS = 1;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * DLY_UNIT_MS;
	localparam int PRE_W = 16;
	localparam int MS_W = 7;
	localparam int SEL_W = 3;

	// Flash geometry
	localparam int ADDR_W = 17;
	localparam int BLK_SHIFT = 8;
	localparam logic [ADDR_W-1:0] FLASH_SIZE = 17'h02000;

	// Fuse values
	localparam logic [7:0] LOCK_OPEN = 8'hc5;
	localparam logic [7:0] SECT_ZERO = 8'h00;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STARTUP = 8'h06;
	localparam logic [7:0] IDX_APP_END = 8'h07;
	localparam logic [7:0] IDX_BOOT_END = 8'h08;
	localparam logic [7:0] IDX_LOCK = 8'h0a;
	localparam logic [7:0] IDX_STATUS = 8'h10;
	localparam int AW = 10;

	// Status register fields
	localparam int ST_OPEN_BIT = 0;
	localparam int ST_FETCH_BIT = 1;
	localparam int ST_LOADED_BIT = 2;

	// AHB
	localparam int HTRANS_ACT_BIT = 1;

	typedef enum logic [1:0] {
		ST_LOAD = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h2
	} fspl_state_t;

	typedef enum logic [1:0] {
		SEC_BOOT = 2'h0,
		SEC_APP_CODE = 2'h1,
		SEC_APP_DATA = 2'h2
	} fspl_sect_t;

	// Byte address of a register index
	function automatic logic [AW-1:0] fspl_addr(input logic [7:0] idx);
		fspl_addr = {idx, 2'h0};
	endfunction

	// Start-up code to milliseconds
	function automatic logic [MS_W-1:0] fspl_delay_ms(
		input logic [SEL_W-1:0] sel);
		if (sel == 3'h0) begin
			fspl_delay_ms = 7'h00;
		end else begin
			fspl_delay_ms = 7'(7'h01 << (sel - 3'h1));
		end
	endfunction
endpackage

// *** fspl_startup_timer.sv ***
// Start-up delay timer: counts whole milliseconds after a start pulse.
// Assumes start_i pulses once after reset and sel_i is stable after it.
`timescale 1ns/1ps
module fspl_startup_timer
	import fspl_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic start_i,
	input wire logic [SEL_W-1:0] sel_i,
	// Result
	output logic done_o
);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_MS - 1);

	logic run_q, run_d;
	logic done_q, done_d;
	logic [PRE_W-1:0] pre_q, pre_d;
	logic [MS_W-1:0] ms_q, ms_d;
	logic [MS_W-1:0] target;

	assign target = fspl_delay_ms(sel_i);
	assign done_o = done_q;

	// Prescaler makes millisecond ticks; counter compares to target
	always_comb begin
		run_d = run_q;
		done_d = done_q;
		pre_d = pre_q;
		ms_d = ms_q;
		if (start_i) begin
			pre_d = '0;
			ms_d = '0;
			run_d = (target != 7'h00);
			done_d = (target == 7'h00);
		end else if (run_q) begin
			if (pre_q == PRE_LAST) begin
				pre_d = '0;
				ms_d = ms_q + 7'h01;
				if (ms_q + 7'h01 == target) begin
					run_d = 1'b0;
					done_d = 1'b1;
				end
			end else begin
				pre_d = pre_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_q <= 1'b0;
			done_q <= 1'b0;
			pre_q <= '0;
			ms_q <= '0;
		end else begin
			run_q <= run_d;
			done_q <= done_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
		end
	end
endmodule

// *** fspl_top.sv ***
// Fuse loader: start-up delay, flash partition bounds, lock state,
// debug-port gating and an AHB-Lite register window.
// Assumes fuse bytes and debug/erase strobes are synchronous to ref_clk_i.
// Fuse inputs must be valid at the first edge after reset release.
// The bus sees a lone zero-wait slave; hreadyout is tied high.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fspl_top
	import fspl_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Fuse array bytes
	input wire logic [SEL_W-1:0] startup_delay_sel_i,
	input wire logic [7:0] app_code_end_i,
	input wire logic [7:0] boot_section_end_i,
	input wire logic [7:0] lock_byte_i,
	input wire logic eeprom_preserve_i,
	// Start-up
	output logic fetch_en_o,
	// Partition
	output logic [ADDR_W-1:0] boot_end_addr_o,
	output logic [ADDR_W-1:0] app_end_addr_o,
	input wire logic [ADDR_W-1:0] sect_addr_i,
	output logic [1:0] sect_o,
	// Debug programming port
	input wire logic dbg_req_i,
	input wire logic dbg_cs_i,
	input wire logic [7:0] dbg_rdata_i,
	output logic dbg_sys_en_o,
	output logic [7:0] dbg_rdata_o,
	output logic dbg_deny_o,
	// Chip erase
	input wire logic chip_erase_i,
	output logic ee_erase_o,
	// Lock byte programming request
	output logic lock_prog_o,
	output logic [7:0] lock_prog_data_o,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	// Fuse copies and load sequence
	fspl_state_t st_q, st_d;
	logic [SEL_W-1:0] sut_q, sut_d;
	logic [7:0] app_q, app_d;
	logic [7:0] boot_q, boot_d;
	logic [7:0] lock_q, lock_d;
	logic eeprom_preserve_q, eeprom_preserve_d;
	logic open_q, open_d;
	logic [ADDR_W-1:0] bend_q, bend_d;
	logic [ADDR_W-1:0] aend_q, aend_d;
	logic tmr_start;
	logic tmr_done;

	// Section lookup and debug/erase outputs
	logic [1:0] sect_q, sect_d;
	logic [7:0] drd_q, drd_d;
	logic deny_q, deny_d;
	logic ee_q, ee_d;

	// Bus state
	logic acc_act;
	logic wr_q, wr_d;
	logic [AW-1:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d;
	logic lp_q, lp_d;
	logic [7:0] lpd_q, lpd_d;
	logic addr_ok;
	logic lock_hit;
	logic [31:0] status_w;

	// Classify a flash address against the latched bounds
	// Bounds are exclusive; an app end at or below the boot end leaves
	// the code section empty, so everything past boot end is data.
	function automatic logic [1:0] sect_of(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] be,
		input logic [ADDR_W-1:0] ae);
		if (a < be) begin
			sect_of = SEC_BOOT;
		end else if (a < ae) begin
			sect_of = SEC_APP_CODE;
		end else begin
			sect_of = SEC_APP_DATA;
		end
	endfunction

	// Capture fuses in the first cycle after reset release, then freeze.
	// Bounds never move while code runs, so no re-decode hazard exists.
	always_comb begin
		st_d = st_q;
		sut_d = sut_q;
		app_d = app_q;
		boot_d = boot_q;
		lock_d = lock_q;
		eeprom_preserve_d = eeprom_preserve_q;
		open_d = open_q;
		bend_d = bend_q;
		aend_d = aend_q;
		tmr_start = 1'b0;
		case (st_q)
			ST_LOAD: begin
				sut_d = startup_delay_sel_i;
				app_d = app_code_end_i;
				boot_d = boot_section_end_i;
				lock_d = lock_byte_i;
				eeprom_preserve_d = eeprom_preserve_i;
				open_d = (lock_byte_i == LOCK_OPEN);
				// Boot end zero wins: whole flash is boot, code end ignored
				// and no application section exists.
				if (boot_section_end_i == SECT_ZERO) begin
					bend_d = FLASH_SIZE;
					aend_d = FLASH_SIZE;
				end else begin
					bend_d = ADDR_W'(boot_section_end_i) << BLK_SHIFT;
					if (app_code_end_i == SECT_ZERO) begin
						aend_d = FLASH_SIZE;
					end else begin
						aend_d = ADDR_W'(app_code_end_i) << BLK_SHIFT;
					end
				end
				tmr_start = 1'b1;
				st_d = ST_WAIT;
			end
			// Hold until the delay timer reports done
			ST_WAIT: begin
				if (tmr_done) begin
					st_d = ST_RUN;
				end
			end
			// Only a reset leaves the run state
			ST_RUN: begin
				st_d = ST_RUN;
			end
			default: begin
				st_d = ST_LOAD;
			end
		endcase
	end

	// Reset keeps the part locked and the whole flash as boot
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= ST_LOAD;
			sut_q <= '0;
			app_q <= '0;
			boot_q <= '0;
			lock_q <= '0;
			eeprom_preserve_q <= 1'b0;
			open_q <= 1'b0;
			bend_q <= FLASH_SIZE;
			aend_q <= FLASH_SIZE;
		end else begin
			st_q <= st_d;
			sut_q <= sut_d;
			app_q <= app_d;
			boot_q <= boot_d;
			lock_q <= lock_d;
			eeprom_preserve_q <= eeprom_preserve_d;
			open_q <= open_d;
			bend_q <= bend_d;
			aend_q <= aend_d;
		end
	end

	// Delay counter; started with the freshly sampled selector
	// The live selector is used; the fuse copy lands one edge late
	fspl_startup_timer #(
		.CYC_MS(CYC_MS)
	) u_tmr (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.start_i(tmr_start),
		.sel_i(startup_delay_sel_i),
		.done_o(tmr_done)
	);

	assign fetch_en_o = (st_q == ST_RUN);
	assign boot_end_addr_o = bend_q;
	assign app_end_addr_o = aend_q;
	assign sect_o = sect_q;
	// Locked until the load cycle proves otherwise
	// so a debugger attached during reset never reaches the system bus
	assign dbg_sys_en_o = open_q;
	assign dbg_rdata_o = drd_q;
	assign dbg_deny_o = deny_q;
	assign ee_erase_o = ee_q;

	// Section lookup, debug read gating and erase decision
	always_comb begin
		// sect_o lags sect_addr_i by one cycle
		sect_d = sect_of(sect_addr_i, bend_q, aend_q);
		drd_d = drd_q;
		deny_d = 1'b0;
		ee_d = 1'b0;
		// Own control/status space stays readable even when locked
		if (dbg_req_i) begin
			if (dbg_cs_i || open_q) begin
				drd_d = dbg_rdata_i;
			end else begin
				// Zero, so no stale byte from an earlier read leaks out
				drd_d = 8'h00;
				deny_d = 1'b1;
			end
		end
		// Latched copies decide, never the live fuse inputs
		if (chip_erase_i) begin
			ee_d = !open_q || !eeprom_preserve_q;
		end
	end

	// Output registers for section, debug port and erase
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sect_q <= SEC_BOOT;
			drd_q <= 8'h00;
			deny_q <= 1'b0;
			ee_q <= 1'b0;
		end else begin
			sect_q <= sect_d;
			drd_q <= drd_d;
			deny_q <= deny_d;
			ee_q <= ee_d;
		end
	end

	// Zero-wait slave: read data is prepared at the address phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_q;
	assign lock_prog_o = lp_q;
	assign lock_prog_data_o = lpd_q;
	assign acc_act = hsel && hready && htrans[HTRANS_ACT_BIT];
	// Upper address bits must be clear, else the lock register aliases
	assign addr_ok = (haddr[31:AW] == '0);
	// Write data is only valid when the data phase completes
	assign lock_hit = wr_q && hready && (wa_q == fspl_addr(IDX_LOCK));

	// Status word; spare bits read as zero
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[ST_OPEN_BIT] = open_q;
		status_w[ST_FETCH_BIT] = (st_q == ST_RUN);
		status_w[ST_LOADED_BIT] = (st_q != ST_LOAD);
	end

	// Address phase capture and read data; writes act a cycle later
	always_comb begin
		wr_d = 1'b0;
		wa_d = wa_q;
		rd_d = rd_q;
		lp_d = 1'b0;
		lpd_d = lpd_q;
		// Write data phase; lock write goes to the fuse programmer only
		if (lock_hit) begin
			lp_d = 1'b1;
			lpd_d = hwdata[7:0];
		end
		if (acc_act) begin
			wr_d = hwrite && addr_ok;
			wa_d = haddr[AW-1:0];
			// Unmapped and out-of-window reads return zero
			rd_d = 32'h0000_0000;
			if (!hwrite && addr_ok) begin
				case (haddr[AW-1:0])
					fspl_addr(IDX_STARTUP): rd_d[SEL_W-1:0] = sut_q;
					fspl_addr(IDX_APP_END): rd_d[7:0] = app_q;
					fspl_addr(IDX_BOOT_END): rd_d[7:0] = boot_q;
					fspl_addr(IDX_LOCK): rd_d[7:0] = lock_q;
					fspl_addr(IDX_STATUS): rd_d = status_w;
					default: rd_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// Bus registers
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= 1'b0;
			wa_q <= '0;
			rd_q <= 32'h0000_0000;
			lp_q <= 1'b0;
			lpd_q <= 8'h00;
		end else begin
			wr_q <= wr_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
			lp_q <= lp_d;
			lpd_q <= lpd_d;
		end
	end
endmodule

// *** fspl_chk_asserts.sv ***
// Checker for the fuse loader top: debug gating, erase, sections, bus.
// Assumes fuse inputs stay constant between resets.
`timescale 1ns/1ps
module fspl_chk
	import fspl_pkg::*;
(
	// Clock, reset and fuses
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] lock_byte_i,
	input wire logic eeprom_preserve_i,
	// Start-up and partition
	input wire logic fetch_en_o,
	input wire logic [ADDR_W-1:0] boot_end_addr_o,
	input wire logic [ADDR_W-1:0] app_end_addr_o,
	input wire logic [ADDR_W-1:0] sect_addr_i,
	input wire logic [1:0] sect_o,
	// Debug port and erase
	input wire logic dbg_req_i,
	input wire logic dbg_cs_i,
	input wire logic [7:0] dbg_rdata_i,
	input wire logic dbg_sys_en_o,
	input wire logic [7:0] dbg_rdata_o,
	input wire logic dbg_deny_o,
	input wire logic chip_erase_i,
	input wire logic ee_erase_o,
	input wire logic lock_prog_o,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// Slave never stalls and never errors
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or erred");
	chk_deny_lock: assert property (
		dbg_req_i && !dbg_cs_i && !dbg_sys_en_o
		|=> dbg_deny_o && dbg_rdata_o == 8'h00)
		else $error("locked system read not denied");
	chk_open_read: assert property (
		dbg_req_i && dbg_sys_en_o
		|=> !dbg_deny_o && dbg_rdata_o == $past(dbg_rdata_i))
		else $error("open read wrong");
	chk_cs_read: assert property (
		dbg_req_i && dbg_cs_i
		|=> !dbg_deny_o && dbg_rdata_o == $past(dbg_rdata_i))
		else $error("own space read wrong");
	chk_erase_ee: assert property (
		chip_erase_i
		|=> ee_erase_o == $past(!dbg_sys_en_o || !eeprom_preserve_i))
		else $error("eeprom erase decision wrong");
	chk_fetch_hold: assert property (
		fetch_en_o |=> fetch_en_o)
		else $error("fetch enable dropped");
	chk_cfg_stable: assert property (
		fetch_en_o |=> $stable(dbg_sys_en_o) && $stable(boot_end_addr_o)
		&& $stable(app_end_addr_o))
		else $error("latched config changed");
	chk_lock_open: assert property (
		fetch_en_o |-> dbg_sys_en_o == (lock_byte_i == LOCK_OPEN))
		else $error("open state wrong");
	chk_sect_map: assert property (
		fetch_en_o |=> sect_o == ($past(sect_addr_i) < boot_end_addr_o
		? 2'h0 : $past(sect_addr_i) < app_end_addr_o ? 2'h1 : 2'h2))
		else $error("section class wrong");
	chk_lock_prog: assert property (
		hsel && hready && htrans[1] && hwrite && haddr == 32'h28
		|-> ##2 lock_prog_o)
		else $error("lock write not requested");
	chk_lock_quiet: assert property (
		!(hsel && hready && htrans[1] && hwrite && haddr == 32'h28)
		|-> ##2 !lock_prog_o)
		else $error("lock request without lock write");

	// Main scenarios reached
	cover property (dbg_deny_o);
	cover property (ee_erase_o);
	cover property (lock_prog_o);
endmodule

bind fspl_top fspl_chk u_chk (
	.ref_clk_i(ref_clk_i),
	.rst_b_i(rst_b_i),
	.lock_byte_i(lock_byte_i),
	.eeprom_preserve_i(eeprom_preserve_i),
	.fetch_en_o(fetch_en_o),
	.boot_end_addr_o(boot_end_addr_o),
	.app_end_addr_o(app_end_addr_o),
	.sect_addr_i(sect_addr_i),
	.sect_o(sect_o),
	.dbg_req_i(dbg_req_i),
	.dbg_cs_i(dbg_cs_i),
	.dbg_rdata_i(dbg_rdata_i),
	.dbg_sys_en_o(dbg_sys_en_o),
	.dbg_rdata_o(dbg_rdata_o),
	.dbg_deny_o(dbg_deny_o),
	.chip_erase_i(chip_erase_i),
	.ee_erase_o(ee_erase_o),
	.lock_prog_o(lock_prog_o),
	.hsel(hsel),
	.haddr(haddr),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp)
);

// *** fspl_dbg_port.sv ***
// Debug port and target model: random requests, data with request only.
// Assumes the bench enables it once fuses are loaded.
`timescale 1ns/1ps
module fspl_dbg_port (
	// Clock and enable
	input wire logic ref_clk_i,
	input wire logic en_i,
	// Request side
	output logic req_o = 1'b0,
	output logic cs_o = 1'b0,
	output logic [7:0] rdata_o = 8'h00
);
	// Data inverted off-request so a stale byte never matches
	always @(posedge ref_clk_i) begin
		automatic logic r = en_i && ($urandom % 3 == 0);
		req_o <= r;
		cs_o <= 1'($urandom);
		rdata_o <= r ? 8'($urandom) : ~rdata_o;
	end
endmodule

// *** testbench.sv ***
// Bench for the fuse loader: random fuse sets over repeated resets.
// Assumes a 20 MHz clock and a shortened millisecond count.
`timescale 1ns/1ps
module testbench
	import fspl_pkg::*;
;
	localparam int CM = 4;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, bg = 1'b0;
	logic [2:0] startup_delay_sel_i = 3'h0, hsize = 3'h2;
	logic [7:0] app_code_end_i = 8'h00, boot_section_end_i = 8'h00;
	logic [7:0] lock_byte_i = 8'h00;
	logic eeprom_preserve_i = 1'b0, chip_erase_i = 1'b0;
	logic [ADDR_W-1:0] sect_addr_i = '0;
	logic hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0;
	wire logic dbg_req_i, dbg_cs_i, fetch_en_o, dbg_sys_en_o, dbg_deny_o;
	wire logic [7:0] dbg_rdata_i, dbg_rdata_o, lock_prog_data_o;
	wire logic ee_erase_o, lock_prog_o, hreadyout, hresp;
	wire logic [ADDR_W-1:0] boot_end_addr_o, app_end_addr_o;
	wire logic [1:0] sect_o;
	wire logic [31:0] hrdata;
	wire logic hready = hreadyout;
	int n_mismatch = 0, checks_done = 0, cyc = 0;

	fspl_top #(.CYC_MS(CM)) u_dut (.*);
	fspl_dbg_port u_dbg (.ref_clk_i(ref_clk_i), .en_i(bg), .req_o(dbg_req_i),
		.cs_o(dbg_cs_i), .rdata_o(dbg_rdata_i));

	initial forever #25 ref_clk_i = ~ref_clk_i;

	// Random traffic; a hang is cut short well past the longest run
	always @(posedge ref_clk_i) begin
		sect_addr_i <= ADDR_W'($urandom % FLASH_SIZE);
		chip_erase_i <= bg && ($urandom % 5 == 0);
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Single AHB-Lite word transfer, waiting on hready each phase
	task automatic ahb(input logic w, input logic [31:0] a, wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [31:0] a, e);
		logic [31:0] rd;
		ahb(1'b0, a, 32'h0, rd);
		chk("reg_read", e, rd);
	endtask

	function automatic int dly(input int s);
		return (s == 0) ? 0 : 1 << (s - 1);
	endfunction

	function automatic logic [ADDR_W-1:0] bend(input logic [7:0] b, a);
		return (b == 8'h00 || a == 8'h00) ? FLASH_SIZE : {1'b0, a, 8'h00};
	endfunction

	initial begin
		logic [31:0] rd, w;
		logic [7:0] a, b, lk;
		int n, e;
		void'($urandom(16487));
		for (int r = 0; r < 8; r++) begin
			bg <= 1'b0;
			rst_b_i <= 1'b0;
			// Corners: both ends zero, code end zero, boot end zero alone
			b = (r == 1 || r == 3) ? 8'h00 : 8'($urandom % 16);
			a = (r == 1 || r == 2) ? 8'h00 : b + 8'($urandom % 16) + 8'h01;
			lk = r[0] ? LOCK_OPEN : 8'($urandom);
			startup_delay_sel_i <= 3'(r);
			app_code_end_i <= a;
			boot_section_end_i <= b;
			lock_byte_i <= lk;
			eeprom_preserve_i <= 1'($urandom);
			repeat (20) @(posedge ref_clk_i);
			rst_b_i <= 1'b1;
			n = 0;
			while (fetch_en_o !== 1'b1) begin
				@(posedge ref_clk_i);
				n++;
			end
			e = dly(r) * CM + 4;
			chk("fetch_delay", 32'h1, 32'(n >= e - 1 && n <= e + 2));
			bg <= 1'b1;
			chk("boot_end", 32'(bend(b, b)), 32'(boot_end_addr_o));
			chk("app_end", 32'(bend(b, a)), 32'(app_end_addr_o));
			rdchk(32'h18, 32'(r));
			rdchk(32'h1c, 32'(a));
			rdchk(32'h20, 32'(b));
			rdchk(32'h40, {29'h0, 2'h3, lk == LOCK_OPEN});
			rdchk(32'h3c, 32'h0);
			w = $urandom;
			ahb(1'b1, 32'h1c, w, rd);
			rdchk(32'h1c, 32'(a));
			ahb(1'b1, 32'h28, w, rd);
			// Aliased lock address outside the window must be ignored
			ahb(1'b1, 32'h428, ~w, rd);
			rdchk(32'h28, 32'(lk));
			chk("lock_prog_data", 32'(w[7:0]), 32'(lock_prog_data_o));
			repeat (30) @(posedge ref_clk_i);
		end
		give_verdict();
	end
endmodule
